// ---- rtl/psc_pkg.sv ----
package psc_pkg;

    // ************************************************************
    // Bus shape
    // ************************************************************
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam int CODE_W = 8;
    localparam int PAGE_WORDS = 4;
    localparam int SYNC_STAGES = 2;
    localparam int TMR_W = 12;
    localparam int PH_W = 4;

    // ************************************************************
    // Timing in printed units and derived cycle counts
    // ************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int PARTIAL_RETENTION_WAKE_TIME_NS = 30;
    localparam int NO_RETENTION_WAKE_TIME_US = 200;
    localparam int POWER_UP_WAIT_US = 200;
    localparam int READ_CYCLE_NS = 65;
    localparam int PAGE_ACCESS_NS = 18;
    localparam int WRITE_PULSE_NS = 50;

    localparam int PARTIAL_WAKE_CYC =
        (PARTIAL_RETENTION_WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int NO_RET_WAKE_CYC =
        (NO_RETENTION_WAKE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWER_UP_CYC =
        (POWER_UP_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_CYC = (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PAGE_CYC = (PAGE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ************************************************************
    // Mode register codes
    // ************************************************************
    localparam logic [CODE_W-1:0] MODE_CODE_BASE = 8'h04;
    localparam logic [CODE_W-1:0] MODE_CODE_MASK = 8'hfc;
    localparam logic [2:0] MODE_STEP_IDLE = 3'h0;
    localparam logic [2:0] MODE_STEP_READ = 3'h1;
    localparam logic [2:0] MODE_STEP_LAST = 3'h4;

    // ************************************************************
    // Commands
    // ************************************************************
    typedef enum logic [2:0] {
        PSC_OP_READ = 3'h0,
        PSC_OP_WRITE = 3'h1,
        PSC_OP_PAGE_READ = 3'h2,
        PSC_OP_SLEEP_KEEP = 3'h3,
        PSC_OP_SLEEP_NONE = 3'h4,
        PSC_OP_WAKE = 3'h5,
        PSC_OP_MODE_SET = 3'h6
    } psc_op_t;

endpackage : psc_pkg

// ---- rtl/psc_timer_if.sv ----
interface psc_timer_if #(
    parameter int TMR_W = psc_pkg::TMR_W
);
    logic load;
    logic [TMR_W-1:0] count;
    logic done;

    modport ctrl (
        output load,
        output count,
        input done
    );

    modport timer (
        input load,
        input count,
        output done
    );
endinterface : psc_timer_if

// ---- rtl/psc_timer.sv ----
module psc_timer #(
    parameter int TMR_W = psc_pkg::TMR_W
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Control side
    psc_timer_if.timer tmr
);

    logic [TMR_W-1:0] cnt_reg;

    // ************************************************************
    // Down counter, done once it reaches zero
    // ************************************************************
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            cnt_reg <= '0;
        end else if (tmr.load) begin
            cnt_reg <= tmr.count;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    assign tmr.done = (cnt_reg == '0) && !tmr.load;

endmodule : psc_timer

// ---- rtl/psc_ctrl.sv ----
// Behaviour
// RL1 - Chip select is already high when the mode pin is driven low for standby.
// RL2 - After partial-retention standby, wait the short wake time before selecting.
// RL3 - After no-retention standby, wait the long wake time before selecting.
// RL4 - Reads hold mode pin and write strobe high.
// RL5 - Page reads keep both lane enables low.
// RL6 - Writes hold mode pin and output enable high.
// RL7 - Address changes only while chip select is high. Page reads step the low address bits while chip select stays low.
// RL8 - Data lines are driven only while output enable is high.
// RL9 - Mode register setting accepts only codes 04h to 07h.
// RL10 - After power-up, wait the power-up time with mode high before selecting.
// RL11 - Chip select stays high throughout standby and its wake time.
module psc_ctrl #(
    parameter int ADDR_W = psc_pkg::ADDR_W,
    parameter int DATA_W = psc_pkg::DATA_W,
    parameter int PAGE_WORDS = psc_pkg::PAGE_WORDS,
    parameter int POWER_UP_CYC = psc_pkg::POWER_UP_CYC,
    parameter int NO_RET_WAKE_CYC = psc_pkg::NO_RET_WAKE_CYC,
    parameter int PARTIAL_WAKE_CYC = psc_pkg::PARTIAL_WAKE_CYC
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Command port
    input wire logic cmd_valid_in,
    input wire logic [2:0] cmd_op_in,
    input wire logic [ADDR_W-1:0] cmd_addr_in,
    input wire logic [DATA_W-1:0] cmd_wdata_in,
    input wire logic [1:0] cmd_lane_n_in,
    input wire logic [psc_pkg::CODE_W-1:0] cmd_code_in,
    output logic cmd_ready_out,
    output logic cmd_err_out,
    // Read answers
    output logic rvalid_out,
    output logic [DATA_W-1:0] rdata_out,
    // Status
    output logic standby_out,
    // Memory pins
    output logic [ADDR_W-1:0] addr_out,
    output logic cs_n_out,
    output logic oe_n_out,
    output logic we_n_out,
    output logic mode_out,
    output logic low_lane_enable_n_out,
    output logic high_lane_enable_n_out,
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe_out
);

    localparam int PAGE_BITS = $clog2(PAGE_WORDS);
    localparam int PH_W = psc_pkg::PH_W;
    localparam int TMR_W = psc_pkg::TMR_W;
    localparam logic [PH_W-1:0] RD_LAST = PH_W'(psc_pkg::READ_CYC + psc_pkg::SYNC_STAGES - 1);
    localparam logic [PH_W-1:0] PG_LAST = PH_W'(psc_pkg::PAGE_CYC + psc_pkg::SYNC_STAGES - 1);
    localparam logic [PH_W-1:0] WP_LAST = PH_W'(psc_pkg::WRITE_PULSE_CYC - 1);
    localparam logic [PH_W-1:0] PG_WORDS_LAST = PH_W'(PAGE_WORDS - 1);

    typedef enum logic [7:0] {
        ST_PWRUP = 8'h01,
        ST_IDLE = 8'h02,
        ST_RD = 8'h04,
        ST_WR_SET = 8'h08,
        ST_WR_PULSE = 8'h10,
        ST_WR_END = 8'h20,
        ST_SLEEP = 8'h40,
        ST_WAKE = 8'h80
    } psc_state_t;

    function automatic logic psc_code_ok(input logic [psc_pkg::CODE_W-1:0] code);
        psc_code_ok = (code & psc_pkg::MODE_CODE_MASK) == psc_pkg::MODE_CODE_BASE;
    endfunction : psc_code_ok

    psc_state_t state_reg;
    logic [PH_W-1:0] phase_reg;
    logic [PH_W-1:0] words_reg;
    logic keep_reg;
    logic [2:0] step_reg;
    logic [psc_pkg::CODE_W-1:0] code_reg;
    logic [DATA_W-1:0] step_data_reg;
    logic tmr_load_reg;
    logic [TMR_W-1:0] tmr_count_reg;
    logic [DATA_W-1:0] dq_meta_reg;
    logic [DATA_W-1:0] dq_sync_reg;

    psc_timer_if #(.TMR_W(TMR_W)) tmr ();

    assign tmr.load = tmr_load_reg;
    assign tmr.count = tmr_count_reg;

    psc_timer #(.TMR_W(TMR_W)) u_timer (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .tmr(tmr)
    );

    // ************************************************************
    // Read data synchroniser
    // ************************************************************
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            dq_meta_reg <= '0;
            dq_sync_reg <= '0;
        end else begin
            dq_meta_reg <= dq_in;
            dq_sync_reg <= dq_meta_reg;
        end
    end

    // ************************************************************
    // Sequencer and memory pins
    // ************************************************************
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            state_reg <= ST_PWRUP;
            phase_reg <= '0;
            words_reg <= '0;
            keep_reg <= 1'b0;
            step_reg <= psc_pkg::MODE_STEP_IDLE;
            code_reg <= '0;
            step_data_reg <= '0;
            tmr_load_reg <= 1'b1;
            tmr_count_reg <= TMR_W'(POWER_UP_CYC); // RL10
            cmd_ready_out <= 1'b0;
            cmd_err_out <= 1'b0;
            rvalid_out <= 1'b0;
            rdata_out <= '0;
            standby_out <= 1'b0;
            addr_out <= '0;
            cs_n_out <= 1'b1;
            oe_n_out <= 1'b1;
            we_n_out <= 1'b1;
            mode_out <= 1'b1;
            low_lane_enable_n_out <= 1'b1;
            high_lane_enable_n_out <= 1'b1;
            dq_out <= '0;
            dq_oe_out <= 1'b0;
        end else begin
            cmd_err_out <= 1'b0;
            rvalid_out <= 1'b0;
            tmr_load_reg <= 1'b0;
            unique case (state_reg)
                ST_PWRUP, ST_WAKE: begin
                    // Chip select held high until the wait is over
                    if (tmr.done) begin // RL2 RL3 RL10 RL11
                        state_reg <= ST_IDLE;
                        standby_out <= 1'b0;
                        cmd_ready_out <= 1'b1;
                    end
                end
                ST_IDLE: begin
                    if (step_reg != psc_pkg::MODE_STEP_IDLE) begin
                        addr_out <= '1; // RL7
                        low_lane_enable_n_out <= 1'b0;
                        high_lane_enable_n_out <= 1'b0;
                        cs_n_out <= 1'b0;
                        if (step_reg == psc_pkg::MODE_STEP_READ) begin
                            oe_n_out <= 1'b0; // RL4
                            phase_reg <= RD_LAST;
                            words_reg <= '0;
                            state_reg <= ST_RD;
                        end else begin
                            dq_out <= (step_reg == psc_pkg::MODE_STEP_LAST) ?
                                DATA_W'(code_reg) : step_data_reg; // RL9
                            dq_oe_out <= 1'b1; // RL6 RL8
                            state_reg <= ST_WR_SET;
                        end
                    end else if (cmd_valid_in && cmd_ready_out) begin
                        unique case (cmd_op_in)
                            psc_pkg::PSC_OP_READ, psc_pkg::PSC_OP_PAGE_READ: begin
                                cmd_ready_out <= 1'b0;
                                addr_out <= cmd_addr_in; // RL7
                                cs_n_out <= 1'b0;
                                oe_n_out <= 1'b0; // RL4
                                phase_reg <= RD_LAST;
                                if (cmd_op_in == psc_pkg::PSC_OP_PAGE_READ) begin
                                    low_lane_enable_n_out <= 1'b0; // RL5
                                    high_lane_enable_n_out <= 1'b0; // RL5
                                    words_reg <= PG_WORDS_LAST;
                                end else begin
                                    low_lane_enable_n_out <= cmd_lane_n_in[0];
                                    high_lane_enable_n_out <= cmd_lane_n_in[1];
                                    words_reg <= '0;
                                end
                                state_reg <= ST_RD;
                            end
                            psc_pkg::PSC_OP_WRITE: begin
                                cmd_ready_out <= 1'b0;
                                addr_out <= cmd_addr_in; // RL7
                                low_lane_enable_n_out <= cmd_lane_n_in[0];
                                high_lane_enable_n_out <= cmd_lane_n_in[1];
                                cs_n_out <= 1'b0;
                                dq_out <= cmd_wdata_in;
                                dq_oe_out <= 1'b1; // RL6 RL8
                                state_reg <= ST_WR_SET;
                            end
                            psc_pkg::PSC_OP_SLEEP_KEEP, psc_pkg::PSC_OP_SLEEP_NONE: begin
                                // Chip select is high in idle, so mode may fall now
                                mode_out <= 1'b0; // RL1
                                keep_reg <= (cmd_op_in == psc_pkg::PSC_OP_SLEEP_KEEP);
                                standby_out <= 1'b1;
                                state_reg <= ST_SLEEP;
                            end
                            psc_pkg::PSC_OP_MODE_SET: begin
                                if (psc_code_ok(cmd_code_in)) begin // RL9
                                    cmd_ready_out <= 1'b0;
                                    code_reg <= cmd_code_in;
                                    step_reg <= psc_pkg::MODE_STEP_READ;
                                end else begin
                                    cmd_err_out <= 1'b1;
                                end
                            end
                            default: begin
                                cmd_err_out <= 1'b1;
                            end
                        endcase
                    end
                end
                ST_RD: begin
                    if (phase_reg != '0) begin
                        phase_reg <= phase_reg - 1'b1;
                    end else begin
                        if (step_reg == psc_pkg::MODE_STEP_READ) begin
                            step_data_reg <= dq_sync_reg;
                        end else begin
                            rdata_out <= dq_sync_reg;
                            rvalid_out <= 1'b1;
                        end
                        if (words_reg != '0) begin
                            words_reg <= words_reg - 1'b1;
                            addr_out[PAGE_BITS-1:0] <=
                                PAGE_BITS'(addr_out[PAGE_BITS-1:0] + 1'b1);
                            phase_reg <= PG_LAST;
                        end else begin
                            cs_n_out <= 1'b1;
                            oe_n_out <= 1'b1;
                            low_lane_enable_n_out <= 1'b1;
                            high_lane_enable_n_out <= 1'b1;
                            state_reg <= ST_IDLE;
                            if (step_reg != psc_pkg::MODE_STEP_IDLE) begin
                                step_reg <= step_reg + 1'b1;
                            end else begin
                                cmd_ready_out <= 1'b1;
                            end
                        end
                    end
                end
                ST_WR_SET: begin
                    we_n_out <= 1'b0;
                    phase_reg <= WP_LAST;
                    state_reg <= ST_WR_PULSE;
                end
                ST_WR_PULSE: begin
                    if (phase_reg != '0) begin
                        phase_reg <= phase_reg - 1'b1;
                    end else begin
                        we_n_out <= 1'b1;
                        cs_n_out <= 1'b1; // RL7
                        state_reg <= ST_WR_END;
                    end
                end
                ST_WR_END: begin
                    dq_oe_out <= 1'b0;
                    low_lane_enable_n_out <= 1'b1;
                    high_lane_enable_n_out <= 1'b1;
                    state_reg <= ST_IDLE;
                    if (step_reg == psc_pkg::MODE_STEP_LAST) begin
                        step_reg <= psc_pkg::MODE_STEP_IDLE;
                        cmd_ready_out <= 1'b1;
                    end else if (step_reg != psc_pkg::MODE_STEP_IDLE) begin
                        step_reg <= step_reg + 1'b1;
                    end else begin
                        cmd_ready_out <= 1'b1;
                    end
                end
                ST_SLEEP: begin
                    if (cmd_valid_in && cmd_ready_out) begin
                        if (cmd_op_in == psc_pkg::PSC_OP_WAKE) begin
                            cmd_ready_out <= 1'b0;
                            mode_out <= 1'b1;
                            tmr_load_reg <= 1'b1;
                            tmr_count_reg <= keep_reg ? TMR_W'(PARTIAL_WAKE_CYC) :
                                TMR_W'(NO_RET_WAKE_CYC); // RL2 RL3
                            state_reg <= ST_WAKE;
                        end else begin
                            cmd_err_out <= 1'b1;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

endmodule : psc_ctrl

// ---- tb/psc_sva.sv ----
module psc_sva #(
    parameter int POWER_UP_CYC = 8,
    parameter int NO_RET_WAKE_CYC = 8,
    parameter int PARTIAL_WAKE_CYC = 1
) (
    // Clock, reset and commands
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic cmd_valid_in,
    input wire logic [2:0] cmd_op_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic cmd_ready_out,
    input wire logic cmd_err_out,
    // Memory pins
    input wire logic [21:0] addr_out,
    input wire logic cs_n_out,
    input wire logic oe_n_out,
    input wire logic we_n_out,
    input wire logic mode_out,
    input wire logic low_lane_enable_n_out,
    input wire logic high_lane_enable_n_out,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    // ****************************************
    // Helpers
    // ****************************************
    logic take;
    logic good;
    logic keep_reg;
    logic boot_reg;
    logic [7:0] code_reg;
    int since_reg;
    int need;
    // Only commands taken outside standby count here; wake acts in standby only
    assign take = cmd_valid_in && cmd_ready_out && mode_out;
    assign good = (cmd_code_in >= 8'h04) && (cmd_code_in <= 8'h07);
    assign need = boot_reg ? POWER_UP_CYC : (keep_reg ? PARTIAL_WAKE_CYC : NO_RET_WAKE_CYC);
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            keep_reg <= 1'b0;
        end else if (take && cmd_op_in == 3'h3) begin
            keep_reg <= 1'b1;
        end else if (take && cmd_op_in == 3'h4) begin
            keep_reg <= 1'b0;
        end
    end
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            boot_reg <= 1'b1;
        end else if (!mode_out) begin
            boot_reg <= 1'b0;
        end
    end
    always_ff @(posedge mclk_in) begin
        if (rst_in || !mode_out) begin
            since_reg <= 0;
        end else if (since_reg < 100000) begin
            since_reg <= since_reg + 1;
        end
    end
    always_ff @(posedge mclk_in) begin
        if (take && cmd_op_in == 3'h6) begin
            code_reg <= cmd_code_in;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    a_read_strobes: assert property (!oe_n_out |-> we_n_out && mode_out)
        else $error("read with write strobe or mode low");
    a_write_strobes: assert property (!we_n_out |-> oe_n_out && mode_out)
        else $error("write with output enable or mode low");
    a_sleep_unselected: assert property (!mode_out |-> cs_n_out)
        else $error("selected while in standby");
    a_dq_no_clash: assert property (dq_oe_out |-> oe_n_out && $past(oe_n_out))
        else $error("data driven while memory may drive");
    a_addr_write_safe: assert property (!$stable(addr_out) && oe_n_out |->
        cs_n_out || we_n_out || (low_lane_enable_n_out && high_lane_enable_n_out))
        else $error("address moved during active write");
    a_wake_recovery: assert property ($fell(cs_n_out) |-> since_reg >= need)
        else $error("select before recovery time");
    a_page_lanes: assert property (take && cmd_op_in == 3'h2 |=>
        (!low_lane_enable_n_out && !high_lane_enable_n_out)[*8])
        else $error("lane released in page read");
    a_bad_code_refused: assert property (take && cmd_op_in == 3'h6 && !good |=> cmd_err_out)
        else $error("bad mode code not refused");
    a_code_written: assert property (take && cmd_op_in == 3'h6 && good |-> ##[1:60]
        (!we_n_out && !cs_n_out && &addr_out && dq_oe_out && dq_out == {8'h00, code_reg}))
        else $error("mode code never written");

    c_page: cover property (take && cmd_op_in == 3'h2);
    c_keep: cover property (take && cmd_op_in == 3'h3);
    c_none: cover property (take && cmd_op_in == 3'h4);
    c_mode: cover property (take && cmd_op_in == 3'h6 && good);
endmodule : psc_sva

// ---- tb/psc_mem_model.sv ----
module psc_mem_model (
    // Memory pins from the host
    input wire logic [21:0] addr_in,
    input wire logic cs_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic mode_in,
    input wire logic low_lane_enable_n_in,
    input wire logic high_lane_enable_n_in,
    input wire logic [15:0] host_dq_in,
    input wire logic host_dq_oe_in,
    // Memory answers
    output logic [15:0] dq_out,
    output logic [15:0] top_word_out,
    output int faults_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [0:63];
    logic [15:0] held = 16'h0000;
    logic drive;
    time up_t = 0;
    initial faults_out = 0;
    assign drive = !cs_n_in && !oe_n_in && we_n_in && mode_in;
    // Released bus shows the inverse of the last word
    assign dq_out = drive ? mem[addr_in[5:0]] : ~held;
    always @(drive, addr_in) if (drive) held = mem[addr_in[5:0]];
    always @(cs_n_in, we_n_in, oe_n_in, mode_in, addr_in, host_dq_in, host_dq_oe_in,
             low_lane_enable_n_in, high_lane_enable_n_in) begin
        if (!cs_n_in && !we_n_in && oe_n_in && mode_in && host_dq_oe_in) begin
            if (!low_lane_enable_n_in) mem[addr_in[5:0]][7:0] = host_dq_in[7:0];
            if (!high_lane_enable_n_in) mem[addr_in[5:0]][15:8] = host_dq_in[15:8];
            if (&addr_in) top_word_out = host_dq_in;
        end
    end
    always @(drive, host_dq_oe_in) if (drive && host_dq_oe_in) faults_out++;
    always @(negedge mode_in) if (!cs_n_in) faults_out++;
    always @(posedge mode_in) up_t = $time;
    always @(negedge cs_n_in) if ($time - up_t < 30) faults_out++;
endmodule : psc_mem_model

// ---- tb/test_psram_standby_and_cycle_rules.sv ----
module test_psram_standby_and_cycle_rules;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic v = 1'b0;
    logic [2:0] op = 3'h0;
    logic [21:0] ad = 22'h0;
    logic [15:0] wd = 16'h0;
    logic [1:0] ln = 2'b00;
    logic [7:0] cd = 8'h00;
    logic rdy, err, rv, sb, cs_n, oe_n, we_n, mode, lo_n, hi_n, dq_oe;
    logic [15:0] rd, dq_h, dq_m, top;
    logic [21:0] addr;
    int faults, mismatches, compares, cycles, took;
    logic [15:0] rq[$];
    logic got_err;

    initial forever #25 mclk_in = ~mclk_in;

    psc_ctrl #(.POWER_UP_CYC(8), .NO_RET_WAKE_CYC(8), .PARTIAL_WAKE_CYC(1)) dut_u (
        .mclk_in(mclk_in), .rst_in(rst_in), .cmd_valid_in(v), .cmd_op_in(op),
        .cmd_addr_in(ad), .cmd_wdata_in(wd), .cmd_lane_n_in(ln), .cmd_code_in(cd),
        .cmd_ready_out(rdy), .cmd_err_out(err), .rvalid_out(rv), .rdata_out(rd),
        .standby_out(sb), .addr_out(addr), .cs_n_out(cs_n), .oe_n_out(oe_n),
        .we_n_out(we_n), .mode_out(mode), .low_lane_enable_n_out(lo_n),
        .high_lane_enable_n_out(hi_n), .dq_in(dq_m), .dq_out(dq_h), .dq_oe_out(dq_oe));
    psc_mem_model mem_u (
        .addr_in(addr), .cs_n_in(cs_n), .oe_n_in(oe_n), .we_n_in(we_n), .mode_in(mode),
        .low_lane_enable_n_in(lo_n), .high_lane_enable_n_in(hi_n), .host_dq_in(dq_h),
        .host_dq_oe_in(dq_oe), .dq_out(dq_m), .top_word_out(top), .faults_out(faults));

    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("ERROR %0t: %s", $time, msg);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    // Issue one command, collect answers until ready returns
    task automatic cmd(input logic [2:0] o, input logic [21:0] a, input logic [15:0] d,
                       input logic [1:0] l, input logic [7:0] c);
        int n;
        rq = {};
        got_err = 1'b0;
        n = 0;
        @(posedge mclk_in);
        v <= 1'b1; op <= o; ad <= a; wd <= d; ln <= l; cd <= c;
        @(posedge mclk_in);
        while (rdy !== 1'b1 && n < 200) begin
            @(posedge mclk_in);
            n++;
        end
        v <= 1'b0;
        for (n = 0; n < 60; n++) begin
            @(posedge mclk_in);
            if (rv === 1'b1) rq.push_back(rd);
            if (err === 1'b1) got_err = 1'b1;
            if (rdy === 1'b1 && n > 0) break;
        end
        took = n;
    endtask : cmd

    task automatic t_power_up();
        int n;
        for (n = 0; n < 100 && rdy !== 1'b1; n++) begin
            @(posedge mclk_in);
            check(cs_n === 1'b1 && mode === 1'b1, "selected during power-up");
        end
        check(n >= 8, "ready too early after power-up");
    endtask : t_power_up

    task automatic t_write_read();
        cmd(psc_pkg::PSC_OP_WRITE, 22'h10, 16'h1234, 2'b00, 8'h00);
        cmd(psc_pkg::PSC_OP_WRITE, 22'h10, 16'habcd, 2'b01, 8'h00);
        cmd(psc_pkg::PSC_OP_READ, 22'h10, 16'h0, 2'b00, 8'h00);
        check(rq.size() == 1 && rq[0] === 16'hab34, "single read data");
    endtask : t_write_read

    task automatic t_page();
        logic [15:0] exp[4];
        for (int i = 0; i < 4; i++) begin
            cmd(psc_pkg::PSC_OP_WRITE, 22'h20 + i, 16'h5a00 + i, 2'b00, 8'h00);
        end
        exp = '{16'h5a02, 16'h5a03, 16'h5a00, 16'h5a01};
        cmd(psc_pkg::PSC_OP_PAGE_READ, 22'h22, 16'h0, 2'b11, 8'h00);
        check(rq.size() == 4, "page word count");
        for (int i = 0; i < 4 && i < rq.size(); i++) check(rq[i] === exp[i], "page data");
    endtask : t_page

    task automatic t_sleep(input logic [2:0] o, input int need);
        cmd(o, 22'h0, 16'h0, 2'b00, 8'h00);
        check(!got_err && mode === 1'b0 && sb === 1'b1 && cs_n === 1'b1, "standby entry");
        cmd(psc_pkg::PSC_OP_READ, 22'h10, 16'h0, 2'b00, 8'h00);
        check(got_err && cs_n === 1'b1 && mode === 1'b0, "read in standby");
        cmd(psc_pkg::PSC_OP_WAKE, 22'h0, 16'h0, 2'b00, 8'h00);
        check(took >= need && sb === 1'b0 && mode === 1'b1, "wake recovery");
        cmd(psc_pkg::PSC_OP_WRITE, 22'h11, 16'h0f0f, 2'b00, 8'h00);
        cmd(psc_pkg::PSC_OP_READ, 22'h11, 16'h0, 2'b00, 8'h00);
        check(rq.size() == 1 && rq[0] === 16'h0f0f, "access after wake");
    endtask : t_sleep

    task automatic t_mode_set();
        logic [7:0] bad[3];
        for (int c = 4; c < 8; c++) begin
            cmd(psc_pkg::PSC_OP_MODE_SET, 22'h0, 16'h0, 2'b00, c[7:0]);
            check(!got_err && top === {8'h00, c[7:0]}, "mode code accepted");
        end
        bad = '{8'h03, 8'h08, 8'h84};
        foreach (bad[i]) begin
            cmd(psc_pkg::PSC_OP_MODE_SET, 22'h0, 16'h0, 2'b00, bad[i]);
            check(got_err, "bad mode code taken");
        end
        cmd(3'h7, 22'h0, 16'h0, 2'b00, 8'h00);
        check(got_err, "illegal op taken");
        cmd(psc_pkg::PSC_OP_WAKE, 22'h0, 16'h0, 2'b00, 8'h00);
        check(got_err, "wake while awake taken");
    endtask : t_mode_set

    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            $display("ERROR %0t: timeout", $time);
            tally_and_finish();
        end
    end

    initial begin
        repeat (3) @(posedge mclk_in);
        rst_in <= 1'b0;
        t_power_up();
        t_write_read();
        t_page();
        t_sleep(psc_pkg::PSC_OP_SLEEP_KEEP, 1);
        t_sleep(psc_pkg::PSC_OP_SLEEP_NONE, 8);
        t_mode_set();
        check(faults == 0, "memory saw pin faults");
        tally_and_finish();
    end
endmodule : test_psram_standby_and_cycle_rules

bind psc_ctrl psc_sva #(
    .POWER_UP_CYC(POWER_UP_CYC), .NO_RET_WAKE_CYC(NO_RET_WAKE_CYC),
    .PARTIAL_WAKE_CYC(PARTIAL_WAKE_CYC)) chk_u (
    .mclk_in(mclk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in), .cmd_op_in(cmd_op_in),
    .cmd_code_in(cmd_code_in), .cmd_ready_out(cmd_ready_out), .cmd_err_out(cmd_err_out),
    .addr_out(addr_out), .cs_n_out(cs_n_out), .oe_n_out(oe_n_out), .we_n_out(we_n_out),
    .mode_out(mode_out), .low_lane_enable_n_out(low_lane_enable_n_out),
    .high_lane_enable_n_out(high_lane_enable_n_out), .dq_out(dq_out), .dq_oe_out(dq_oe_out));
